// file: design/twsm_pkg.sv
package twsm_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h160;
    localparam logic [11:0] OFS_DATA = 12'h164;
    localparam logic [11:0] OFS_IRQ = 12'h168;
    localparam logic [11:0] OFS_BB = 12'h16C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_FLAG_POS = 31;
    localparam int CTRL_TREG_LSB = 16;
    localparam int CTRL_SSEL_LSB = 9;
    localparam int CTRL_BURST_POS = 4;
    localparam int CTRL_SIZE_LSB = 1;
    localparam int CTRL_STOP_POS = 0;
    localparam int IRQ_CLR_POS = 0;
    localparam int BB_DIR_POS = 2;
    localparam int BB_DATA_POS = 1;
    localparam int BB_CLK_POS = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [14:0] TREG_RST = 15'h0000;
    localparam logic [6:0] SSEL_RST = 7'h00;
    localparam logic [2:0] SIZE_RST = 3'h0;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic BB_DIR_RST = 1'b0;
    localparam logic BB_DATA_RST = 1'b0;
    localparam logic BB_CLK_RST = 1'b1;

    // ------------------------------------------------------------
    // timing: each bus bit is four equal quarters
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int BUS_CLK_HZ = 100_000;
    localparam int QUARTER_CYC = SYS_CLK_HZ / (4 * BUS_CLK_HZ);

    // ------------------------------------------------------------
    // sequencer stages and bit operations
    // ------------------------------------------------------------
    localparam logic [2:0] STG_SSEL_W = 3'h0;
    localparam logic [2:0] STG_ADDR_HI = 3'h1;
    localparam logic [2:0] STG_ADDR_LO = 3'h2;
    localparam logic [2:0] STG_DATA = 3'h3;
    localparam logic [2:0] STG_SSEL_R = 3'h4;
    localparam logic [1:0] BURST_LAST = 2'h3;

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP = 2'h1,
        OP_BIT = 2'h2
    } twsm_op_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_START = 8'h02,
        ST_TXBIT = 8'h04,
        ST_TXACK = 8'h08,
        ST_RXBIT = 8'h10,
        ST_RXACK = 8'h20,
        ST_STOP = 8'h40,
        ST_FIN = 8'h80
    } twsm_state_t;

    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_Q0 = 5'h02,
        PH_Q1 = 5'h04,
        PH_Q2 = 5'h08,
        PH_Q3 = 5'h10
    } twsm_phase_t;
endpackage

// file: design/twsm_bit_if.sv
`timescale 1ns/10ps
interface twsm_bit_if;
    import twsm_pkg::*;
    logic req;
    twsm_op_t op;
    logic wbit;
    logic done;
    logic rbit;
    logic sda_low;
    logic scl_low;
    logic sda_in;
    logic scl_in;

    modport seq (output req, output op, output wbit, output sda_in, output scl_in,
                 input done, input rbit, input sda_low, input scl_low);
    modport engine (input req, input op, input wbit, input sda_in, input scl_in,
                    output done, output rbit, output sda_low, output scl_low);
endinterface

// file: design/twsm_bit_engine.sv
`timescale 1ns/10ps
module twsm_bit_engine #(
    parameter int QUARTER = twsm_pkg::QUARTER_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // bit operations from the sequencer
    twsm_bit_if.engine bus
);
    import twsm_pkg::*;

    twsm_phase_t ph_r;
    twsm_op_t op_r;
    logic wbit_r;
    logic [15:0] qcnt_r;
    logic rbit_r;
    logic sda_low_r;
    logic scl_low_r;
    logic sda_rel;
    logic scl_rel;
    wire tick = (qcnt_r == 16'(QUARTER - 1));
    // slave may stretch: first high quarter (Q1) does not end while clock pin is held low
    wire advance = tick && !(ph_r == PH_Q1 && !bus.scl_in);
    wire taking = (ph_r == PH_IDLE) && bus.req;

    // ------------------------------------------------------------
    // line levels per operation and quarter (1 = released)
    // ------------------------------------------------------------
    always_comb begin
        sda_rel = wbit_r;
        scl_rel = (ph_r == PH_Q1) || (ph_r == PH_Q2);
        case (op_r)
            OP_START: begin
                sda_rel = (ph_r == PH_Q0) || (ph_r == PH_Q1);
            end
            OP_STOP: begin
                sda_rel = (ph_r == PH_Q2) || (ph_r == PH_Q3);
                scl_rel = (ph_r != PH_Q0);
            end
            default: begin
                sda_rel = wbit_r;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ph_r <= PH_IDLE;
            op_r <= OP_STOP;
            wbit_r <= 1'b1;
            qcnt_r <= 16'h0000;
            rbit_r <= 1'b1;
            sda_low_r <= 1'b0;
            scl_low_r <= 1'b0;
        end else begin
            // hold at the quarter end while stretched, else the tick is lost and the bit hangs
            if (ph_r == PH_IDLE || advance) begin
                qcnt_r <= 16'h0000;
            end else if (!tick) begin
                qcnt_r <= qcnt_r + 16'h0001;
            end
            if (taking) begin
                op_r <= bus.op;
                wbit_r <= bus.wbit;
                ph_r <= PH_Q0;
            end else if (advance) begin
                case (ph_r)
                    PH_Q0: ph_r <= PH_Q1;
                    PH_Q1: ph_r <= PH_Q2;
                    PH_Q2: ph_r <= PH_Q3;
                    default: ph_r <= PH_IDLE;
                endcase
            end
            if (ph_r == PH_Q1 && advance) begin
                rbit_r <= bus.sda_in;
            end
            // lines only ever pulled low or let go; idle holds last level
            if (ph_r != PH_IDLE) begin
                sda_low_r <= !sda_rel;
                scl_low_r <= !scl_rel;
            end
        end
    end

    assign bus.done = (ph_r == PH_Q3) && advance;
    assign bus.rbit = rbit_r;
    assign bus.sda_low = sda_low_r;
    assign bus.scl_low = scl_low_r;
endmodule

// file: design/twsm_top.sv
`timescale 1ns/10ps
// Overview of operation
// - writing flag one starts a write; flag reads zero once finished
// - writing flag zero starts a read; flag reads one once finished
// - every finished sequenced transfer raises the interrupt request
// - register address inside the slave comes from the 15-bit field
// - slave select byte comes from the 7-bit select field
// - burst clear moves one byte; set moves four, the whole 32-bit data register
// - 3-bit size code gives 256 to 32768 bytes; resets to 256
// - stop request ends transfer at next byte boundary, toggles flag, reads zero
// - read bytes land in the data register as each byte is acknowledged
// - writing one to interrupt bit 0 clears the pending request
// - sequencer runs the serial protocol itself at 100 kHz
// - bit-bang: direction bit 2, data bit 1, clock bit 0 resetting to one
// - bit-bang data reads pin when input, written value when output
module twsm_top (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // completion request
    output logic twsm_irq,
    // two-wire bus pins
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe
);
    import twsm_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sda_s1_r;
    logic sda_s2_r;
    logic scl_s1_r;
    logic scl_s2_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
        end else begin
            sda_s1_r <= serial_data_pin_i;
            sda_s2_r <= sda_s1_r;
            scl_s1_r <= serial_clock_pin_i;
            scl_s2_r <= scl_s1_r;
        end
    end

    twsm_bit_if bif();
    assign bif.sda_in = sda_s2_r;
    assign bif.scl_in = scl_s2_r;

    twsm_bit_engine #(.QUARTER(QUARTER_CYC)) u_engine (
        .mclk(mclk),
        .reset_n(reset_n),
        .bus(bif)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic flag_r;
    logic [14:0] treg_r;
    logic [6:0] ssel_r;
    logic burst_r;
    logic [2:0] size_r;
    logic [31:0] data_r;
    logic irq_r;
    logic bb_dir_r;
    logic bb_data_r;
    logic bb_clk_r;
    logic stop_req_r;
    logic [31:0] rdata_r;

    twsm_state_t state_r;
    twsm_state_t state_nxt;
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic [2:0] bit_cnt_r;
    logic [1:0] byte_cnt_r;
    logic [7:0] rx_sh_r;
    logic write_r;
    logic pend_r;

    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_data = reg_wr && (reg_addr == OFS_DATA);
    wire wr_irq = reg_wr && (reg_addr == OFS_IRQ);
    wire wr_bb = reg_wr && (reg_addr == OFS_BB);
    wire busy = (state_r != ST_IDLE);
    wire start_go = wr_ctrl && !busy;
    wire finish = (state_r == ST_FIN);
    wire last_byte = (byte_cnt_r == (burst_r ? BURST_LAST : 2'h0));
    wire two_addr = (size_r != SIZE_RST);
    // unused upper address bits forced to zero for the selected size
    wire [15:0] addr_mask = 16'h7FFF >> (3'h7 - size_r);
    wire [15:0] taddr = {1'b0, treg_r} & addr_mask;
    wire [7:0] tx_byte =
        (stage_r == STG_SSEL_W) ? {ssel_r, 1'b0} :
        (stage_r == STG_SSEL_R) ? {ssel_r, 1'b1} :
        (stage_r == STG_ADDR_HI) ? taddr[15:8] :
        (stage_r == STG_ADDR_LO) ? taddr[7:0] :
        data_r[{byte_cnt_r, 3'b000} +: 8];
    wire in_op = (state_r != ST_IDLE) && (state_r != ST_FIN);
    wire nack = bif.rbit;

    // ------------------------------------------------------------
    // requests to the bit engine
    // ------------------------------------------------------------
    assign bif.req = in_op && !pend_r;
    assign bif.op = (state_r == ST_START) ? OP_START :
                    (state_r == ST_STOP) ? OP_STOP : OP_BIT;
    assign bif.wbit = (state_r == ST_TXBIT) ? tx_byte[3'h7 - bit_cnt_r] :
                      (state_r == ST_RXACK) ? last_byte : 1'b1;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        stage_nxt = stage_r;
        case (state_r)
            ST_IDLE: begin
                if (start_go) begin
                    state_nxt = ST_START;
                    stage_nxt = STG_SSEL_W;
                end
            end
            ST_START: begin
                if (bif.done) begin
                    state_nxt = ST_TXBIT;
                end
            end
            ST_TXBIT: begin
                if (bif.done && bit_cnt_r == 3'h7) begin
                    state_nxt = ST_TXACK;
                end
            end
            ST_TXACK: begin
                if (bif.done) begin
                    state_nxt = ST_TXBIT;
                    if (nack || stop_req_r) begin
                        state_nxt = ST_STOP;
                    end else if (stage_r == STG_SSEL_W) begin
                        stage_nxt = two_addr ? STG_ADDR_HI : STG_ADDR_LO;
                    end else if (stage_r == STG_ADDR_HI) begin
                        stage_nxt = STG_ADDR_LO;
                    end else if (stage_r == STG_ADDR_LO) begin
                        stage_nxt = write_r ? STG_DATA : STG_SSEL_R;
                        state_nxt = write_r ? ST_TXBIT : ST_START;
                    end else if (stage_r == STG_DATA) begin
                        state_nxt = last_byte ? ST_STOP : ST_TXBIT;
                    end else begin
                        state_nxt = ST_RXBIT;
                    end
                end
            end
            ST_RXBIT: begin
                if (bif.done && bit_cnt_r == 3'h7) begin
                    state_nxt = ST_RXACK;
                end
            end
            ST_RXACK: begin
                if (bif.done) begin
                    state_nxt = (last_byte || stop_req_r) ? ST_STOP : ST_RXBIT;
                end
            end
            ST_STOP: begin
                if (bif.done) begin
                    state_nxt = ST_FIN;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            stage_r <= STG_SSEL_W;
            pend_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 2'h0;
            rx_sh_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            stage_r <= stage_nxt;
            pend_r <= bif.req || (pend_r && !bif.done);
            if (state_r == ST_IDLE) begin
                bit_cnt_r <= 3'h0;
                byte_cnt_r <= 2'h0;
            end else if (bif.done && (state_r == ST_TXBIT || state_r == ST_RXBIT)) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (bif.done && state_r == ST_RXBIT) begin
                rx_sh_r <= {rx_sh_r[6:0], bif.rbit};
            end
            if (bif.done && !last_byte &&
                ((state_r == ST_TXACK && stage_r == STG_DATA) || state_r == ST_RXACK)) begin
                byte_cnt_r <= byte_cnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // control, data and completion
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
            write_r <= 1'b0;
            treg_r <= TREG_RST;
            ssel_r <= SSEL_RST;
            burst_r <= 1'b0;
            size_r <= SIZE_RST;
            stop_req_r <= 1'b0;
        end else begin
            if (start_go) begin
                flag_r <= reg_wdata[CTRL_FLAG_POS];
                write_r <= reg_wdata[CTRL_FLAG_POS];
                treg_r <= reg_wdata[CTRL_TREG_LSB +: 15];
                ssel_r <= reg_wdata[CTRL_SSEL_LSB +: 7];
                burst_r <= reg_wdata[CTRL_BURST_POS];
                size_r <= reg_wdata[CTRL_SIZE_LSB +: 3];
            end else if (finish) begin
                flag_r <= !flag_r;
            end
            // a stop arriving while idle has nothing to end
            if (finish || !busy) begin
                stop_req_r <= 1'b0;
            end else if (wr_ctrl && reg_wdata[CTRL_STOP_POS]) begin
                stop_req_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            data_r <= DATA_RST;
            irq_r <= 1'b0;
        end else begin
            if (start_go && !reg_wdata[CTRL_FLAG_POS]) begin
                data_r <= DATA_RST;
            end else if (bif.done && state_r == ST_RXACK) begin
                data_r[{byte_cnt_r, 3'b000} +: 8] <= rx_sh_r;
            end else if (wr_data && !busy) begin
                data_r <= reg_wdata;
            end
            // a completion in the clearing cycle is kept
            if (finish) begin
                irq_r <= 1'b1;
            end else if (wr_irq && reg_wdata[IRQ_CLR_POS]) begin
                irq_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // bit-bang register and pins
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bb_dir_r <= BB_DIR_RST;
            bb_data_r <= BB_DATA_RST;
            bb_clk_r <= BB_CLK_RST;
        end else if (wr_bb) begin
            bb_dir_r <= reg_wdata[BB_DIR_POS];
            bb_data_r <= reg_wdata[BB_DATA_POS];
            bb_clk_r <= reg_wdata[BB_CLK_POS];
        end
    end

    // reset values of the bit-bang bits leave both lines released
    assign serial_data_pin_oe = bif.sda_low || bb_dir_r;
    assign serial_data_pin_o = bif.sda_low ? 1'b0 : bb_data_r;
    assign serial_clock_pin_oe = bif.scl_low || !bb_clk_r;
    assign serial_clock_pin_o = 1'b0;

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    wire bb_data_rd = bb_dir_r ? bb_data_r : sda_s2_r;
    wire [31:0] ctrl_rd = {flag_r, treg_r, ssel_r, 4'h0, burst_r, size_r, 1'b0};
    wire [31:0] rd_mux =
        (reg_addr == OFS_CTRL) ? ctrl_rd :
        (reg_addr == OFS_DATA) ? data_r :
        (reg_addr == OFS_IRQ) ? {31'h0000_0000, irq_r} :
        (reg_addr == OFS_BB) ? {29'h0000_0000, bb_dir_r, bb_data_rd, bb_clk_r} :
        32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign reg_rdata = rdata_r;
    assign twsm_irq = irq_r;
endmodule

// file: tb/twsm_sva.sv
`timescale 1ns/10ps
// ----
// port checker for the two-wire master
// ----
module twsm_sva
    import twsm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic twsm_irq,
    // bus pins
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_data_pin_i,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe
);
    logic dir_r;
    logic busy_r;
    logic st_r;
    logic [7:0] hi_r;
    wire wr_ctl = reg_wr && reg_addr == OFS_CTRL;
    wire clr_irq = reg_wr && reg_addr == OFS_IRQ && reg_wdata[IRQ_CLR_POS];
    wire dir_nxt = (reg_wr && reg_addr == OFS_BB) ? reg_wdata[BB_DIR_POS] : dir_r;
    wire busy_nxt = (wr_ctl && !busy_r) || (busy_r && !twsm_irq);
    // a high phase cut short by a stretching slave is no rate error
    wire st_nxt = busy_r && !serial_clock_pin_oe && (st_r || !serial_clock_pin_i);
    wire [7:0] hi_nxt = (busy_r && !serial_clock_pin_oe) ? hi_r + 8'(serial_clock_pin_i) : 8'h00;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dir_r <= 1'b0;
            busy_r <= 1'b0;
            st_r <= 1'b0;
            hi_r <= 8'h00;
        end else begin
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
            st_r <= st_nxt;
            hi_r <= hi_nxt;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    clk_low_only_a: assert property (!serial_clock_pin_o)
        else $error("clock pin driven high");
    data_low_only_a: assert property (
        serial_data_pin_oe && !dir_r |-> !serial_data_pin_o)
        else $error("sequencer drove data high");
    irq_clear_a: assert property (clr_irq && twsm_irq && !busy_r |=> !twsm_irq)
        else $error("interrupt not cleared");
    irq_sticky_a: assert property (twsm_irq && !clr_irq |=> twsm_irq)
        else $error("interrupt dropped by itself");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    ctrl_read_a: assert property (
        reg_rd && reg_addr == OFS_CTRL |=> reg_rdata[CTRL_STOP_POS] == 1'b0)
        else $error("stop bit read back set");
    bb_read_a: assert property (
        reg_rd && reg_addr == OFS_BB |=> reg_rdata[BB_DIR_POS] == dir_r)
        else $error("bit-bang direction read wrong");
    start_soon_a: assert property (wr_ctl && !busy_r |-> ##[1:8] serial_clock_pin_oe)
        else $error("transfer did not start");
    bit_rate_a: assert property (
        busy_r && !st_r && $rose(serial_clock_pin_oe) && hi_r > 8'd20 |->
        hi_r inside {[8'd96:8'd104]})
        else $error("bus clock high phase off rate");
    done_c: cover property ($rose(twsm_irq));
    stretch_c: cover property (busy_r && !serial_clock_pin_oe && !serial_clock_pin_i);
    bb_drive_c: cover property (serial_data_pin_oe && dir_r);
endmodule

bind twsm_top twsm_sva twsm_sva_inst (.mclk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .twsm_irq, .serial_clock_pin_i, .serial_clock_pin_o,
    .serial_clock_pin_oe, .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe);

// file: tb/twsm_sensor_model.sv
`timescale 1ns/10ps
// ----
// sensor slave on the two-wire bus
// ----
module twsm_sensor_model #(
    parameter logic [6:0] SEL = 7'h4D,
    parameter int LINK_NS = 400
) (
    // resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // read source and pacing
    input wire logic [31:0] rd_word,
    input wire logic stretch,
    // open drain pulls
    output logic sda_low,
    output logic scl_low
);
    logic [7:0] log_q[$];
    logic [7:0] sh;
    logic [7:0] tx;
    logic act = 0;
    logic first, rd, rd_nxt, ack;
    int bitn, k;
    initial begin
        sda_low = 0;
        scl_low = 0;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1;
        first = 1;
        rd = 0;
        // the clock fall that closes the start is not a bit
        bitn = -1;
        k = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        act = 0;
        sda_low = 0;
    end
    always @(posedge scl) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else ack = !sda;
    end
    always @(negedge scl) if (act) begin
        if (bitn < 8) begin
            bitn++;
            if (bitn < 8) sda_low = rd && !tx[7 - bitn];
            else if (rd) sda_low = 0;
            else begin
                ack = !first || sh[7:1] == SEL;
                if (first) rd_nxt = sh[0];
                else log_q.push_back(sh);
                sda_low = ack;
            end
        end else begin
            bitn = 0;
            if (first) rd = rd_nxt;
            first = 0;
            tx = rd_word[8 * (k % 4) +: 8];
            sda_low = rd && ack && !tx[7];
            if (rd && ack) k++;
            // slow answer: hold the clock low past the master's low phase
            if (stretch) begin
                scl_low = 1;
                #(20 * LINK_NS) scl_low = 0;
            end
        end
    end
endmodule

// file: tb/two_wire_sensor_master_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end
// ----
// bench for the two-wire master
// ----
module two_wire_sensor_master_test;
    import twsm_pkg::*;
    localparam logic [6:0] SEL = 7'h4D;
    logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, tb_sda_low = 0, stretch = 0;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_word = 0, got;
    logic twsm_irq, scl_oe, scl_o, sda_oe, sda_o, m_sda_low, m_scl_low;
    logic [7:0] eq[$];
    int miscompares = 0, checks_done = 0, seed = 95205;
    // pull-ups on both lines; every party only pulls low except the bit-bang data output, which can drive high
    wire scl = !scl_oe && !m_scl_low;
    wire sda = (sda_oe ? sda_o : 1'b1) && !m_sda_low && !tb_sda_low;
    twsm_top twsm_top_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .twsm_irq(twsm_irq), .serial_clock_pin_i(scl), .serial_clock_pin_o(scl_o),
        .serial_clock_pin_oe(scl_oe), .serial_data_pin_i(sda), .serial_data_pin_o(sda_o),
        .serial_data_pin_oe(sda_oe));
    twsm_sensor_model #(.SEL(SEL)) twsm_sensor_model_inst (.scl(scl), .sda(sda),
        .rd_word(rd_word), .stretch(stretch), .sda_low(m_sda_low), .scl_low(m_scl_low));
    initial forever #25 mclk = ~mclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        #2 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge mclk);
        #2 reg_wr = 0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        #2 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge mclk);
        #2 reg_rd = 0;
        d = reg_rdata;
    endtask
    task automatic head(input logic [14:0] t, input logic [2:0] s);
        logic [15:0] a;
        a = {1'b0, t} & (16'h7FFF >> (3'h7 - s));
        eq = {};
        if (s != 3'h0) eq.push_back(a[15:8]);
        eq.push_back(a[7:0]);
    endtask
    task automatic chk_log();
        `CHK("log size", eq.size(), twsm_sensor_model_inst.log_q.size())
        foreach (eq[i]) `CHK("log byte", eq[i], twsm_sensor_model_inst.log_q[i])
        twsm_sensor_model_inst.log_q.delete();
    endtask
    task automatic xfer(input logic f, input logic [6:0] sel, input logic [14:0] t,
                        input logic b, input logic [2:0] s, input int stop_at);
        int n;
        wr(OFS_IRQ, 32'h1);
        wr(OFS_CTRL, {f, t, sel, 4'h0, b, s, 1'b0});
        if (stop_at > 0) begin
            repeat (stop_at) @(posedge mclk);
            wr(OFS_DATA, ~reg_wdata);
            wr(OFS_CTRL, 32'h1);
        end
        for (n = 0; n < 30000 && twsm_irq !== 1'b1; n++) @(posedge mclk);
        if (n == 30000) begin
            miscompares++;
            conclude();
        end
        rd(OFS_CTRL, got);
        `CHK("flag", ~f, got[CTRL_FLAG_POS])
        `CHK("ctrl fields", {t, sel, 4'h0, b, s, 1'b0}, got[30:0])
        `CHK("irq", 1'b1, twsm_irq)
        wr(OFS_IRQ, 32'h1);
        `CHK("irq clear", 1'b0, twsm_irq)
        $display("transfer flag %b size %0d done", f, s);
    endtask
    initial begin
        logic [14:0] t;
        logic [31:0] d;
        logic [2:0] v;
        repeat (12) @(posedge mclk);
        #2 reset_n = 1;
        rd(OFS_CTRL, got);
        `CHK("ctrl reset", 32'h0, got)
        rd(OFS_DATA, got);
        `CHK("data reset", DATA_RST, got)
        rd(OFS_BB, got);
        `CHK("bitbang reset", 32'h3, got)
        rd(12'h170, got);
        `CHK("unmapped", 32'h0, got)
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            tb_sda_low = 1'($random(seed));
            wr(OFS_BB, {29'h0, v});
            repeat (3) @(posedge mclk);
            rd(OFS_BB, got);
            `CHK("bitbang read", {29'h0, v[2], v[2] ? v[1] : !tb_sda_low, v[0]}, got)
            `CHK("clock line", v[0], scl)
            `CHK("data drive", v[2], sda_oe)
        end
        tb_sda_low = 0;
        wr(OFS_BB, 32'h1);
        $display("bit-bang test done");
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            t = 15'($random(seed));
            d = $random(seed);
            wr(OFS_DATA, d);
            xfer(1'b1, SEL, t, v == 3'h7, v, 0);
            head(t, v);
            for (int j = 0; j < ((v == 3'h7) ? 4 : 1); j++) eq.push_back(d[8 * j +: 8]);
            chk_log();
        end
        t = 15'($random(seed));
        rd_word = $random(seed);
        stretch = 1;
        xfer(1'b0, SEL, t, 1'b1, 3'h3, 0);
        stretch = 0;
        rd(OFS_DATA, got);
        `CHK("burst read", rd_word, got)
        head(t, 3'h3);
        chk_log();
        xfer(1'b0, SEL, t, 1'b0, 3'h0, 0);
        rd(OFS_DATA, got);
        `CHK("single read", {24'h0, rd_word[7:0]}, got)
        head(t, 3'h0);
        chk_log();
        xfer(1'b1, SEL ^ 7'h01, t, 1'b0, 3'h0, 0);
        eq = {};
        chk_log();
        wr(OFS_DATA, d);
        xfer(1'b1, SEL, t, 1'b1, 3'h0, 600);
        rd(OFS_DATA, got);
        `CHK("data kept while busy", d, got)
        chk_log();
        conclude();
    end
endmodule
